// ===== err_report_pkg.sv
// package for the memory bridge error reporting block
// assumes a single 50 MHz core clock and a 32-bit apb register bus
package err_report_pkg;

  // register byte offsets
  localparam logic [7:0] first_error_status_off  = 8'h00;
  localparam logic [7:0] next_error_status_off   = 8'h04;
  localparam logic [7:0] error_signal_mask_off   = 8'h08;
  localparam logic [7:0] link_error_log_off      = 8'h0c;
  localparam logic [7:0] config_access_log_off   = 8'h10;
  localparam logic [7:0] memory_recov_log_off    = 8'h14;
  localparam logic [7:0] memory_nonrecov_log_off = 8'h18;
  localparam logic [7:0] memory_data_log_off     = 8'h1c;
  localparam logic [7:0] control_off             = 8'h20;

  // error source count and bit positions
  localparam int n_err = 16;
  localparam int e_crc          = 0;
  localparam int e_many_wdata   = 1;
  localparam int e_few_wdata    = 2;
  localparam int e_unimpl_cmd   = 3;
  localparam int e_wdata_poison = 4;
  localparam int e_rd_overflow  = 5;
  localparam int e_restricted_w = 6;
  localparam int e_cfg_poison   = 7;
  localparam int e_ecc_corr     = 8;
  localparam int e_ecc_multi    = 9;
  localparam int e_wpb_parity   = 10;
  localparam int e_spare_fix    = 11;
  localparam int e_wbuf_ovf     = 12;
  localparam int e_cfg_twice    = 13;
  localparam int e_alias_fatal  = 14;
  localparam int e_mem_init     = 15;

  // severity of each source: 0 corr, 1 uncorr, 2 fatal
  localparam logic [n_err-1:0] sev_fatal  = 16'h4400;
  localparam logic [n_err-1:0] sev_uncorr = 16'h0000;

  // reset values
  localparam logic [n_err-1:0] mask_rst = 16'h0000;
  localparam logic [31:0]      zero32   = 32'h0000_0000;

  // virtual signal codes on the inbound link
  typedef enum logic [2:0] {
    vs_none, vs_fatal, vs_uncorr, vs_corr, vs_machine_check, vs_io_hub_reset
  } vsig_t;

  // one error event with its details
  typedef struct packed {
    logic [n_err-1:0] src;
    logic [31:0]      addr;
    logic [31:0]      data;
    logic             ecc_reread_ok;
    logic             req_read;
  } err_event_t;

  // actions handed back to the datapath
  typedef struct packed {
    logic flush_write;
    logic nack;
    logic abort;
    logic drop;
    logic poison_store;
    logic write_back;
  } err_action_t;

endpackage : err_report_pkg

// ===== sticky_bits.sv
// sticky bit vector: hardware sets, software clears by writing ones
// assumes power_good_n is the only reset that wipes it
`timescale 1ns/1ps
module sticky_bits
  import err_report_pkg::*;
#(
  parameter int width = 16
) (
  // clock and power reset
  input  wire logic             pclk,
  input  wire logic             power_good_n,
  // set and clear
  input  wire logic [width-1:0] set_bits,
  input  wire logic [width-1:0] clr_bits,
  // state
  output logic      [width-1:0] bits_q
);

  logic [width-1:0] bits_d;

  // set wins over a clear in the same cycle
  assign bits_d = (bits_q & ~clr_bits) | set_bits;

  // survives link reset, cleared only by power loss or by software writing ones
  always_ff @(posedge pclk or negedge power_good_n) begin
    if (!power_good_n) bits_q <= '0;
    else               bits_q <= bits_d;
  end

endmodule : sticky_bits

// ===== err_report.sv
// error detection, status capture, logging and signalling block
// assumes apb on pclk, power_good_n as the power-good reset, presetn as the link reset
`timescale 1ns/1ps
module err_report
  import err_report_pkg::*;
(
  // clock and resets
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        power_good_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // error events from the datapath
  input  wire err_event_t  evt,
  input  wire logic        secure_mode,
  input  wire logic        reset_busy,
  input  wire logic        mc_request,
  input  wire logic        hub_reset_request,
  // actions back to the datapath
  output err_action_t      act_q,
  // inbound link virtual signal
  output vsig_t            vsig_q,
  output logic             vsig_valid_q
);

  ////////////////////////////////////////////////////////////////////////
  // event qualification
  logic [n_err-1:0] src_ok;
  logic [n_err-1:0] is_fatal;
  logic [n_err-1:0] is_uncorr;
  logic [n_err-1:0] is_corr;
  logic             any_err;
  logic             ev_fatal;
  logic             ev_uncorr;
  logic             ev_corr;
  logic             link_up_q;

  // low while the link reset is held, so events seen then never reach status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) link_up_q <= 1'b0;
    else          link_up_q <= 1'b1;
  end

  // drop everything seen while a reset is underway
  assign src_ok    = (reset_busy || !link_up_q) ? '0 : evt.src;
  // multibit read from request is uncorrectable, from scrub corr
  assign is_fatal  = src_ok & sev_fatal;
  assign is_uncorr = src_ok & (sev_uncorr | ((evt.req_read ? 16'h0001 : 16'h0000) << e_ecc_multi));
  assign is_corr   = src_ok & ~is_fatal & ~is_uncorr;
  assign any_err   = |src_ok;
  assign ev_fatal  = |is_fatal;
  assign ev_uncorr = |is_uncorr;
  assign ev_corr   = |is_corr;

  ////////////////////////////////////////////////////////////////////////
  // status registers
  logic [n_err-1:0] first_q;
  logic [n_err-1:0] next_q;
  logic [n_err-1:0] first_set;
  logic [n_err-1:0] next_set;
  logic [n_err-1:0] first_clr;
  logic [n_err-1:0] next_clr;
  logic             have_fatal;
  logic             have_nonfatal;
  logic             take_fatal;
  logic             take_nonfatal;

  assign have_fatal    = |(first_q & sev_fatal);
  assign have_nonfatal = |(first_q & ~sev_fatal);
  assign take_fatal    = ev_fatal & ~have_fatal;
  assign take_nonfatal = (ev_corr | ev_uncorr) & ~have_nonfatal;
  // first fatal and first nonfatal, corr and uncorr alike, to first status, the rest to next status
  assign first_set = (take_fatal ? is_fatal : '0) | (take_nonfatal ? (is_corr | is_uncorr) : '0);
  assign next_set  = src_ok & ~first_set;

  // status held across link reset by the power reset only
  sticky_bits #(.width(n_err)) u_first (
    .pclk         (pclk),
    .power_good_n (power_good_n),
    .set_bits     (first_set),
    .clr_bits     (first_clr),
    .bits_q       (first_q)
  );
  sticky_bits #(.width(n_err)) u_next (
    .pclk         (pclk),
    .power_good_n (power_good_n),
    .set_bits     (next_set),
    .clr_bits     (next_clr),
    .bits_q       (next_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // apb decode
  logic apb_wr;
  logic apb_rd;
  logic hit_first;
  logic hit_next;
  logic hit_mask;
  logic hit_ctl;
  logic mapped;

  assign apb_wr    = psel & penable & pwrite;
  assign apb_rd    = psel & penable & ~pwrite;
  assign hit_first = paddr == first_error_status_off;
  assign hit_next  = paddr == next_error_status_off;
  assign hit_mask  = paddr == error_signal_mask_off;
  assign hit_ctl   = paddr == control_off;
  assign mapped    = hit_first | hit_next | hit_mask | hit_ctl |
                     (paddr == link_error_log_off) | (paddr == config_access_log_off) |
                     (paddr == memory_recov_log_off) | (paddr == memory_nonrecov_log_off) |
                     (paddr == memory_data_log_off);
  assign first_clr = (apb_wr & hit_first) ? pwdata[n_err-1:0] : '0;
  assign next_clr  = (apb_wr & hit_next) ? pwdata[n_err-1:0] : '0;
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~mapped;

  ////////////////////////////////////////////////////////////////////////
  // logs, frozen per class while their first status bits stand
  logic [31:0] link_log_q;
  logic [31:0] cfg_log_q;
  logic [31:0] rec_log_q;
  logic [31:0] nonrec_log_q;
  logic [31:0] data_log_q;
  logic        cap_corr;
  logic        cap_uncorr;
  logic        cap_fatal;
  logic        cap_rec;
  logic [n_err-1:0] rec_src;
  logic [n_err-1:0] cfg_src;
  logic [n_err-1:0] link_src;
  logic [n_err-1:0] uncorr_slots;

  // uncorrectable first bits: the request-read multibit slot
  assign uncorr_slots = sev_uncorr | (16'h0001 << e_ecc_multi);

  // capture decided by first status alone, next status unused
  assign cap_fatal  = ev_fatal & ~have_fatal;
  assign cap_corr   = ev_corr & ~|(first_q & ~sev_fatal & ~uncorr_slots);
  assign cap_uncorr = ev_uncorr & ~|(first_q & uncorr_slots);
  assign cap_rec    = cap_corr | cap_uncorr;
  // which sources feed which log; fatal sources go to the nonrecoverable log instead
  assign link_src   = src_ok & ((16'h0001 << e_crc) | (16'h0001 << e_unimpl_cmd));
  assign cfg_src    = src_ok & ((16'h0001 << e_restricted_w) | (16'h0001 << e_cfg_poison) |
                                (16'h0001 << e_cfg_twice));
  assign rec_src    = src_ok & ((16'h0001 << e_rd_overflow) | (16'h0001 << e_ecc_corr) |
                                (16'h0001 << e_ecc_multi) | (16'h0001 << e_spare_fix) |
                                (16'h0001 << e_wbuf_ovf) | (16'h0001 << e_mem_init));

  // link and config logs take address plus source
  always_ff @(posedge pclk or negedge power_good_n) begin
    if (!power_good_n) begin
      link_log_q <= zero32;
      cfg_log_q  <= zero32;
    end else begin
      if (cap_corr && |link_src) link_log_q <= {evt.addr[15:0], link_src};
      if (cap_corr && |cfg_src)  cfg_log_q  <= {evt.addr[15:0], cfg_src};
    end
  end

  // memory logs: recoverable, nonrecoverable, data if not secure
  always_ff @(posedge pclk or negedge power_good_n) begin
    if (!power_good_n) begin
      rec_log_q    <= zero32;
      nonrec_log_q <= zero32;
      data_log_q   <= zero32;
    end else begin
      if (cap_rec && |rec_src) rec_log_q <= evt.addr;
      if (cap_fatal) nonrec_log_q <= evt.addr;
      if (cap_rec && (src_ok[e_ecc_corr] | src_ok[e_ecc_multi]) && !secure_mode)
        data_log_q <= evt.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mask and control
  logic [n_err-1:0] mask_q;
  logic             ctl_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= mask_rst;
      ctl_q  <= 1'b0;
    end else begin
      if (apb_wr && hit_mask) mask_q <= pwdata[n_err-1:0];
      if (apb_wr && hit_ctl)  ctl_q  <= pwdata[0];
    end
  end

  // read data mux
  logic [31:0] rd_mux;
  assign rd_mux = hit_first ? {16'h0000, first_q} :
                  hit_next  ? {16'h0000, next_q} :
                  hit_mask  ? {16'h0000, mask_q} :
                  hit_ctl   ? {31'h0, ctl_q} :
                  (paddr == link_error_log_off)      ? link_log_q :
                  (paddr == config_access_log_off)   ? cfg_log_q :
                  (paddr == memory_recov_log_off)    ? rec_log_q :
                  (paddr == memory_nonrecov_log_off) ? nonrec_log_q :
                  (paddr == memory_data_log_off)     ? data_log_q : zero32;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= zero32;
    else if (psel && !penable && !pwrite) prdata <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////////
  // datapath actions
  err_action_t act_d;
  assign act_d.flush_write  = src_ok[e_crc] | src_ok[e_many_wdata] | src_ok[e_few_wdata];
  assign act_d.nack         = src_ok[e_unimpl_cmd] | src_ok[e_cfg_poison] | src_ok[e_mem_init];
  assign act_d.abort        = src_ok[e_rd_overflow] | src_ok[e_cfg_twice];
  assign act_d.drop         = src_ok[e_restricted_w] | src_ok[e_cfg_poison] |
                              src_ok[e_wbuf_ovf] | src_ok[e_mem_init];
  assign act_d.poison_store = src_ok[e_wdata_poison];
  assign act_d.write_back   = src_ok[e_ecc_corr] |
                              ((src_ok[e_ecc_multi] | src_ok[e_spare_fix]) & evt.ecc_reread_ok);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) act_q <= '0;
    else          act_q <= act_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // link signalling, highest severity first
  logic  sig_fatal;
  logic  sig_uncorr;
  logic  sig_corr;
  vsig_t vsig_d;

  assign sig_fatal  = |(is_fatal & ~mask_q);
  assign sig_uncorr = |(is_uncorr & ~mask_q);
  assign sig_corr   = |(is_corr & ~mask_q);
  assign vsig_d = reset_busy        ? vs_none :
                  sig_fatal         ? vs_fatal :
                  sig_uncorr        ? vs_uncorr :
                  sig_corr          ? vs_corr :
                  mc_request        ? vs_machine_check :
                  hub_reset_request ? vs_io_hub_reset : vs_none;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vsig_q       <= vs_none;
      vsig_valid_q <= 1'b0;
    end else begin
      vsig_q       <= vsig_d;
      vsig_valid_q <= vsig_d != vs_none;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions
  property p_first_fatal;
    @(posedge pclk) disable iff (!power_good_n) take_fatal |=> |(first_q & sev_fatal);
  endproperty
  a_first_fatal: assert property (p_first_fatal) else $error("first fatal not recorded");

  property p_next_later;
    @(posedge pclk) disable iff (!power_good_n) (ev_fatal && have_fatal) |=> |(next_q & sev_fatal);
  endproperty
  a_next_later: assert property (p_next_later) else $error("later fatal not in next status");

  property p_sticky;
    @(posedge pclk) disable iff (!power_good_n)
      (!presetn && first_clr == '0) |=> first_q == ($past(first_q) | $past(first_set));
  endproperty
  a_sticky: assert property (p_sticky) else $error("first status lost in link reset");

  property p_frozen;
    @(posedge pclk) disable iff (!power_good_n) (have_fatal && !(first_clr != '0)) |=> $stable(nonrec_log_q);
  endproperty
  a_frozen: assert property (p_frozen) else $error("fatal log changed while frozen");

  property p_flush;
    @(posedge pclk) disable iff (!presetn) src_ok[e_crc] |=> act_q.flush_write;
  endproperty
  a_flush: assert property (p_flush) else $error("crc error did not flush");

  property p_nack;
    @(posedge pclk) disable iff (!presetn) (src_ok[e_unimpl_cmd] || src_ok[e_mem_init]) |=> act_q.nack;
  endproperty
  a_nack: assert property (p_nack) else $error("missing nack");

  property p_poison;
    @(posedge pclk) disable iff (!presetn) src_ok[e_wdata_poison] |=> act_q.poison_store;
  endproperty
  a_poison: assert property (p_poison) else $error("poisoned write not stored poisoned");

  property p_mask;
    @(posedge pclk) disable iff (!presetn) (!reset_busy && sig_fatal) |=> vsig_q == vs_fatal;
  endproperty
  a_mask: assert property (p_mask) else $error("fatal code not sent");

  property p_reset_quiet;
    @(posedge pclk) disable iff (!power_good_n) reset_busy |=> (first_q & ~$past(first_q)) == '0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("error captured during reset");

  property p_abort;
    @(posedge pclk) disable iff (!presetn) (src_ok[e_rd_overflow] || src_ok[e_cfg_twice]) |=> act_q.abort;
  endproperty
  a_abort: assert property (p_abort) else $error("overflow or second config command not aborted");

  property p_drop;
    @(posedge pclk) disable iff (!presetn) (src_ok[e_restricted_w] || src_ok[e_wbuf_ovf]) |=> act_q.drop;
  endproperty
  a_drop: assert property (p_drop) else $error("rejected write not dropped");

  property p_write_back;
    @(posedge pclk) disable iff (!presetn) src_ok[e_ecc_corr] |=> act_q.write_back;
  endproperty
  a_write_back: assert property (p_write_back) else $error("correctable ecc not written back");

  property p_multi_keep;
    @(posedge pclk) disable iff (!presetn)
      (src_ok[e_ecc_multi] && !evt.ecc_reread_ok && !src_ok[e_ecc_corr] && !src_ok[e_spare_fix]) |=> !act_q.write_back;
  endproperty
  a_multi_keep: assert property (p_multi_keep) else $error("uncorrectable location rewritten");

  property p_nonrec;
    @(posedge pclk) disable iff (!power_good_n) cap_fatal |=> nonrec_log_q == $past(evt.addr);
  endproperty
  a_nonrec: assert property (p_nonrec) else $error("first fatal address not logged");

  c_fatal:    cover property (@(posedge pclk) take_fatal);
  c_corr:     cover property (@(posedge pclk) vsig_q == vs_corr);
  c_masked:   cover property (@(posedge pclk) ev_corr && !sig_corr);
  c_next:     cover property (@(posedge pclk) any_err && have_nonfatal);
  c_bad_read: cover property (@(posedge pclk) apb_rd && !mapped);

endmodule : err_report

// ===== hub_link_model.sv
// hub controller end of the inbound link: records the virtual signal codes
// assumes codes change right after pclk rising edges
`timescale 1ns/1ps
module hub_link_model
  import err_report_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // bench control
  input  wire logic       clr,
  // inbound virtual signal
  input  wire vsig_t      vsig_q,
  input  wire logic       vsig_valid_q,
  // what was received
  output vsig_t           last_q,
  output logic      [7:0] count_q
);
  ////////////////////////////////////////////////////////////////////////////
  // latch every valid code outside clr cycles, count them; clr starts a fresh window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_q  <= vs_none;
      count_q <= 8'h00;
    end else if (clr) begin
      last_q  <= vs_none;
      count_q <= 8'h00;
    end else if (vsig_valid_q) begin
      last_q  <= vsig_q;
      count_q <= count_q + 8'h01;
    end
  end
endmodule : hub_link_model

// ===== tb_err_report.sv
// self-checking bench for the error reporting block
// assumes zero-wait apb and outputs one cycle after each event pulse
`timescale 1ns/1ps
module tb_err_report;
  import err_report_pkg::*;
  logic        pclk = 0, presetn = 0, power_good_n = 0;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, e;
  err_event_t  evt = '0;
  logic        secure_mode = 0, reset_busy = 0, mc_request = 0, hub_reset_request = 0, clr = 0;
  err_action_t act_q;
  vsig_t       vsig_q, last_q;
  logic        vsig_valid_q;
  logic [7:0]  count_q;
  int          bad_count = 0, checked = 0;
  typedef struct { int idx; logic [5:0] act; vsig_t vs; } row_t;
  row_t        rows [16];
  ////////////////////////////////////////////////////////////////////////////
  // clock, design and far end
  always #10 pclk = ~pclk;
  err_report err_report_inst (.pclk(pclk), .presetn(presetn), .power_good_n(power_good_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .evt(evt), .secure_mode(secure_mode), .reset_busy(reset_busy),
    .mc_request(mc_request), .hub_reset_request(hub_reset_request), .act_q(act_q), .vsig_q(vsig_q),
    .vsig_valid_q(vsig_valid_q));
  hub_link_model hub_link_model_inst (.pclk(pclk), .presetn(presetn), .clr(clr), .vsig_q(vsig_q),
    .vsig_valid_q(vsig_valid_q), .last_q(last_q), .count_q(count_q));
  ////////////////////////////////////////////////////////////////////////////
  // verdict and compares
  task give_verdict;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task cmp32(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp32
  task cmp_act(input logic [5:0] care, input logic [5:0] exp);
    cmp32({26'h0, act_q & care}, {26'h0, exp});
  endtask : cmp_act
  task cmp_vs(input vsig_t exp);
    if (exp == vs_none) cmp32({24'h0, count_q}, 32'h0);
    else cmp32({29'h0, last_q}, {29'h0, exp});
  endtask : cmp_vs
  ////////////////////////////////////////////////////////////////////////////
  // apb master: setup, access held until pready sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    r = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
    if (pready !== 1'b1) begin
      bad_count++;
      give_verdict();
    end
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(0, a, 32'h0);
    cmp32(r, exp);
  endtask : rd
  task clear_status;
    apb(1, first_error_status_off, 32'hffff);
    apb(1, next_error_status_off, 32'hffff);
  endtask : clear_status
  // one event pulse, action check one cycle on, link code seen by the far end
  task fire(input int idx, input logic [31:0] ad, input logic ok, input logic rq,
            input logic [5:0] care, input logic [5:0] ex, input vsig_t vs);
    @(posedge pclk);
    clr <= 1;
    evt <= '{src: 16'h1 << idx, addr: ad, data: ~ad, ecc_reread_ok: ok, req_read: rq};
    @(posedge pclk);
    clr <= 0;
    evt.src <= 16'h0;
    #1 cmp_act(care, ex);
    @(posedge pclk);
    #1 cmp_vs(vs);
  endtask : fire
  task power_reset;
    @(posedge pclk);
    presetn <= 0; power_good_n <= 0;
    repeat (10) @(posedge pclk);
    presetn <= 1; power_good_n <= 1;
  endtask : power_reset
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rows = '{'{0, 6'h20, vs_corr}, '{1, 6'h20, vs_corr}, '{2, 6'h20, vs_corr}, '{3, 6'h10, vs_corr},
             '{4, 6'h02, vs_corr}, '{5, 6'h08, vs_corr}, '{6, 6'h04, vs_corr}, '{7, 6'h14, vs_corr},
             '{8, 6'h01, vs_corr}, '{9, 6'h01, vs_corr}, '{10, 6'h00, vs_fatal}, '{11, 6'h01, vs_corr},
             '{12, 6'h04, vs_corr}, '{13, 6'h08, vs_corr}, '{14, 6'h00, vs_fatal}, '{15, 6'h14, vs_corr}};
    power_reset();
    for (int i = 0; i < 16; i++) begin
      clear_status();
      fire(rows[i].idx, 32'h100 + i, 1, 0, 6'h3f, rows[i].act, rows[i].vs);
      rd(first_error_status_off, 32'h1 << rows[i].idx);
      rd(next_error_status_off, 32'h0);
    end
    rd(link_error_log_off, 32'h0103_0008);
    rd(config_access_log_off, 32'h010d_2000);
    // first and next split, frozen logs, fatal in its own log
    clear_status();
    fire(e_ecc_corr, 32'ha1, 1, 0, 6'h3f, 6'h01, vs_corr);
    fire(e_wbuf_ovf, 32'ha2, 1, 0, 6'h3f, 6'h04, vs_corr);
    rd(first_error_status_off, 32'h0100);
    rd(next_error_status_off, 32'h1000);
    rd(memory_recov_log_off, 32'ha1);
    fire(e_wpb_parity, 32'ha3, 1, 0, 6'h3f, 6'h00, vs_fatal);
    rd(first_error_status_off, 32'h0500);
    rd(memory_nonrecov_log_off, 32'ha3);
    apb(1, next_error_status_off, 32'hffff);
    fire(e_rd_overflow, 32'ha5, 1, 0, 6'h3f, 6'h08, vs_corr);
    rd(memory_recov_log_off, 32'ha1);
    apb(1, first_error_status_off, 32'h0100);
    fire(e_spare_fix, 32'ha4, 1, 0, 6'h3f, 6'h01, vs_corr);
    rd(memory_recov_log_off, 32'ha4);
    // link reset keeps status; the mask, never written since power reset, reads zero
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rd(first_error_status_off, 32'h0c00);
    rd(next_error_status_off, 32'h0020);
    rd(error_signal_mask_off, 32'h0);
    // masked signalling, events during reset, uncorrectable request read
    apb(1, error_signal_mask_off, 32'h1 << e_unimpl_cmd);
    clear_status();
    fire(e_unimpl_cmd, 32'hb1, 1, 0, 6'h3f, 6'h10, vs_none);
    rd(link_error_log_off, 32'h00b1_0008);
    apb(1, error_signal_mask_off, 32'h0);
    clear_status();
    @(posedge pclk);
    reset_busy <= 1;
    fire(e_crc, 32'hb2, 1, 0, 6'h3f, 6'h00, vs_none);
    @(posedge pclk);
    reset_busy <= 0;
    rd(first_error_status_off, 32'h0);
    fire(e_ecc_multi, 32'hb3, 0, 1, 6'h3f, 6'h00, vs_uncorr);
    // power reset wipes all, secure mode hides data
    power_reset();
    for (int a = 0; a <= 8'h20; a += 4) rd(a[7:0], 32'h0);
    @(posedge pclk);
    secure_mode <= 1;
    fire(e_ecc_corr, 32'hc1, 1, 0, 6'h3f, 6'h01, vs_corr);
    rd(memory_data_log_off, 32'h0);
    @(posedge pclk);
    secure_mode <= 0;
    clear_status();
    fire(e_ecc_corr, 32'hc2, 1, 0, 6'h3f, 6'h01, vs_corr);
    rd(memory_data_log_off, ~32'hc2);
    clear_status();
    // machine check and hub reset codes with no error pending
    @(posedge pclk);
    mc_request <= 1;
    repeat (3) @(posedge pclk);
    #1 cmp32({29'h0, vsig_q}, {29'h0, vs_machine_check});
    @(posedge pclk);
    mc_request <= 0;
    hub_reset_request <= 1;
    repeat (3) @(posedge pclk);
    #1 cmp32({29'h0, vsig_q}, {29'h0, vs_io_hub_reset});
    @(posedge pclk);
    hub_reset_request <= 0;
    // unmapped address refused
    apb(0, 8'hfc, 32'h0);
    cmp32({31'h0, e}, 32'h1);
    cmp32(r, 32'h0);
    give_verdict();
  end
endmodule : tb_err_report
